// ---- rtl/tmwave_defines.svh ----
// register offsets, field positions, masks, reset values and interrupt bit positions of the waveform timer
// Operation
// - nonzero output-mode field routes the channel waveform onto its pin
// - non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match
// - fast PWM: 2 clears on match, sets at TOP; 3 the reverse
// - PWM channel A value 1: off if mode top bit 0, else toggle on match
// - phase-correct: 2 clears on up match, sets on down match; 3 reverse
// - PWM with compare equal TOP and mode bit 1 set: act at TOP only
// - non-PWM channel B uses the same encoding as channel A
// - fast PWM channel B value 1 reserved; 2 and 3 as channel A
// - phase-correct channel B value 1 reserved; 2 and 3 as channel A
// - first control bits 3 and 2 always read zero
// - three-bit wave mode: low two bits here, top bit in second control
// - decode modes 0..7 with TOP 0xFF or compare A; 4 and 6 reserved
// - overflow sets at MAX for 0,2,3; BOTTOM for 1,5; TOP for 7
`ifndef TMWAVE_DEFINES_SVH
`define TMWAVE_DEFINES_SVH
`define TMW_ADR_CTRL_A    4'h0
`define TMW_ADR_CTRL_B    4'h1
`define TMW_ADR_COUNT     4'h2
`define TMW_ADR_CMP_A     4'h3
`define TMW_ADR_CMP_B     4'h4
`define TMW_ADR_IRQ_STAT  4'h5
`define TMW_ADR_IRQ_MASK  4'h6
`define TMW_ADR_TICK_DIV  4'h7
`define TMW_CA_MODE_HI    7
`define TMW_CA_MODE_LO    6
`define TMW_CB_MODE_HI    5
`define TMW_CB_MODE_LO    4
`define TMW_WM_LOW_HI     1
`define TMW_WM_TOP_BIT    3
`define TMW_CTRL_A_MASK   8'hF3
`define TMW_CTRL_B_MASK   8'h08
`define TMW_CTRL_RESET    8'h00
`define TMW_MAX           8'hFF
`define TMW_BOTTOM        8'h00
`define TMW_IRQ_OVF       0
`define TMW_IRQ_CMPA      1
`define TMW_IRQ_CMPB      2
`define TMW_IRQ_MASK_BITS 8'h07
`define TMW_TICK_DIV_RST  8'h00
`endif

// ---- rtl/tmw_pkg.sv ----
// types shared by the waveform timer files
package tmw_pkg;
    typedef enum logic [2:0] {
        TMW_NORMAL, TMW_PC_FF, TMW_CTC, TMW_FAST_FF,
        TMW_RSV4, TMW_PC_CMPA, TMW_RSV6, TMW_FAST_CMPA
    } tmw_mode_e;
    typedef struct packed {
        logic       we;
        logic [3:0] adr;
        logic [7:0] dat;
    } tmw_wr_s;
    typedef struct packed {
        logic [1:0] mode_a;
        logic [1:0] mode_b;
        logic [1:0] wm_low;
    } tmw_ctrl_s;
endpackage : tmw_pkg

// ---- rtl/tmw_wave_chan.sv ----
// one compare channel: active compare, buffer, and waveform bit
`timescale 1ns/10ps
`include "tmwave_defines.svh"
module tmw_wave_chan
    import tmw_pkg::*;
#(
    parameter bit IS_CHAN_A = 1'b1
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // software side
    input  wire logic       cmp_wr_i,
    input  wire logic [7:0] cmp_dat_i,
    input  wire logic [1:0] out_mode_i,
    input  wire logic       top_bit_i,
    // timer side
    input  wire logic       tick_i,
    input  wire logic [7:0] count_i,
    input  wire logic [7:0] top_i,
    input  wire logic       at_top_i,
    input  wire logic       at_bottom_i,
    input  wire logic       down_i,
    input  wire logic       pwm_i,
    input  wire logic       fast_i,
    // results
    output logic [7:0]      cmp_o,
    output logic [7:0]      act_o,
    output logic            match_o,
    output logic            wave_o
);
    logic [7:0] buf_q;
    logic [7:0] act_q;
    logic       wave_q;
    logic       wave_d;
    logic       match;
    logic       top_case;

    assign cmp_o   = buf_q;
    assign act_o   = act_q;
    assign wave_o  = wave_q;
    assign match   = tick_i && (count_i == act_q);
    assign match_o = match;
    assign top_case = pwm_i && (act_q == top_i) && out_mode_i[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_q <= `TMW_BOTTOM;
        end else if (cmp_wr_i) begin
            buf_q <= cmp_dat_i;
        end
    end

    // pwm copies at TOP so a period never sees a half-updated duty
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_q <= `TMW_BOTTOM;
        end else if (!pwm_i && cmp_wr_i) begin
            act_q <= cmp_dat_i;
        end else if (!pwm_i) begin
            act_q <= buf_q;
        end else if (tick_i && at_top_i) begin
            act_q <= buf_q;
        end
    end

    always_comb begin
        wave_d = wave_q;
        if (!pwm_i) begin
            if (match) begin
                case (out_mode_i)
                    2'b01:   wave_d = !wave_q;
                    2'b10:   wave_d = 1'b0;
                    2'b11:   wave_d = 1'b1;
                    default: wave_d = wave_q;
                endcase
            end
        end else if (out_mode_i == 2'b01) begin
            // channel B treats value 1 as reserved and holds
            if (IS_CHAN_A && top_bit_i && match) begin
                wave_d = !wave_q;
            end
        end else if (out_mode_i[1]) begin
            if (fast_i) begin
                // compare equal to TOP: the match is dropped, the TOP action stands
                if (tick_i && at_top_i) begin
                    wave_d = !out_mode_i[0];
                end else if (match && !top_case) begin
                    wave_d = out_mode_i[0];
                end
            end else begin
                if (top_case && tick_i && at_top_i) begin
                    wave_d = !out_mode_i[0];
                end else if (match && !top_case) begin
                    wave_d = down_i ? !out_mode_i[0] : out_mode_i[0];
                end else if (tick_i && at_bottom_i && act_q == `TMW_BOTTOM) begin
                    wave_d = out_mode_i[0];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end
endmodule : tmw_wave_chan

// ---- rtl/tmw_timer.sv ----
// waveform timer top: wishbone registers, counter, mode decode, pins, interrupt
`timescale 1ns/10ps
`include "tmwave_defines.svh"
module tmw_timer
    import tmw_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // wishbone slave
    input  wire logic       cyc_i,
    input  wire logic       stb_i,
    input  wire logic       we_i,
    input  wire logic [3:0] adr_i,
    input  wire logic [3:0] sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]     dat_o,
    output logic            ack_o,
    // waveform pins
    output logic            chan_a_wave_out_o,
    output logic            chan_a_wave_en_o,
    output logic            chan_b_wave_out_o,
    output logic            chan_b_wave_en_o,
    // interrupt
    output logic            irq_o
);
    tmw_ctrl_s  ctrl_q;
    logic       top_bit_q;
    logic [2:0] clk_sel_q;
    logic [7:0] count_q;
    logic       down_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic [7:0] div_q;
    logic [7:0] div_cnt_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    logic       pa_q, pa_en_q, pb_q, pb_en_q, irq_q;
    tmw_wr_s    wr;
    logic       bus_req;
    logic       lane0;
    tmw_mode_e  mode;
    logic       pwm, fast, pc;
    logic [7:0] top;
    logic       tick, at_top, at_bottom;
    logic [7:0] cmp_a, cmp_b;
    logic       match_a, match_b;
    logic       wave_a, wave_b;
    logic [1:0]      chan_wr;
    logic [1:0][1:0] chan_mode;
    logic [1:0][7:0] chan_cmp;
    logic [1:0][7:0] chan_act;
    logic [1:0]      chan_match;
    logic [1:0]      chan_wave;
    logic       ovf_ev;
    logic       clr_cnt;
    logic [2:0] ev;

    assign bus_req = cyc_i && stb_i && !ack_q;
    assign lane0   = sel_i[0];
    assign wr.we   = bus_req && we_i && lane0;
    assign wr.adr  = adr_i;
    assign wr.dat  = dat_i[7:0];

    // mode decode from both control registers
    // TOP follows the active compare, so in the PWM modes a buffered write never moves TOP mid-period; in CTC a write moves it at once
    assign mode = tmw_mode_e'({top_bit_q, ctrl_q.wm_low});
    always_comb begin
        pwm  = 1'b0;
        fast = 1'b0;
        pc   = 1'b0;
        top  = `TMW_MAX;
        case (mode)
            TMW_NORMAL:    top = `TMW_MAX;
            TMW_PC_FF:     begin pwm = 1'b1; pc = 1'b1; end
            TMW_CTC:       top = chan_act[0];
            TMW_FAST_FF:   begin pwm = 1'b1; fast = 1'b1; end
            TMW_PC_CMPA:   begin pwm = 1'b1; pc = 1'b1; top = chan_act[0]; end
            TMW_FAST_CMPA: begin pwm = 1'b1; fast = 1'b1; top = chan_act[0]; end
            default:       top = `TMW_MAX;
        endcase
    end

    // prescaling kept simple: stopped when select is zero, else div register
    assign tick      = (clk_sel_q != 3'h0) && (div_cnt_q == div_q);
    assign at_top    = (count_q == top);
    assign at_bottom = (count_q == `TMW_BOTTOM);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_q <= `TMW_TICK_DIV_RST;
        end else if (tick || clk_sel_q == 3'h0) begin
            div_cnt_q <= `TMW_TICK_DIV_RST;
        end else begin
            div_cnt_q <= div_cnt_q + 8'h01;
        end
    end

    assign clr_cnt = wr.we && wr.adr == `TMW_ADR_COUNT;

    // counter sequence per mode; reserved modes count as normal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= `TMW_BOTTOM;
            down_q  <= 1'b0;
        end else if (clr_cnt) begin
            count_q <= wr.dat;
        end else if (tick) begin
            if (pc) begin
                if (!down_q && at_top) begin
                    down_q  <= 1'b1;
                    count_q <= count_q - 8'h01;
                end else if (down_q && at_bottom) begin
                    down_q  <= 1'b0;
                    count_q <= count_q + 8'h01;
                end else begin
                    count_q <= down_q ? count_q - 8'h01 : count_q + 8'h01;
                end
            end else if ((mode == TMW_CTC || fast) && at_top) begin
                count_q <= `TMW_BOTTOM;
                down_q  <= 1'b0;
            end else begin
                count_q <= count_q + 8'h01;
                down_q  <= 1'b0;
            end
        end
    end

    always_comb begin
        ovf_ev = 1'b0;
        if (tick) begin
            case (mode)
                TMW_PC_FF, TMW_PC_CMPA: ovf_ev = at_bottom && down_q;
                TMW_FAST_CMPA:          ovf_ev = at_top;
                default:                ovf_ev = (count_q == `TMW_MAX);
            endcase
        end
    end

    assign chan_wr[0]   = wr.we && wr.adr == `TMW_ADR_CMP_A;
    assign chan_wr[1]   = wr.we && wr.adr == `TMW_ADR_CMP_B;
    assign chan_mode[0] = ctrl_q.mode_a;
    assign chan_mode[1] = ctrl_q.mode_b;

    // index 0 is channel a; only it owns the pwm toggle code
    for (genvar g = 0; g < 2; g++) begin : g_chan
        tmw_wave_chan #(
            .IS_CHAN_A (g == 0)
        ) u_chan (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .cmp_wr_i    (chan_wr[g]),
            .cmp_dat_i   (wr.dat),
            .out_mode_i  (chan_mode[g]),
            .top_bit_i   (top_bit_q),
            .tick_i      (tick),
            .count_i     (count_q),
            .top_i       (top),
            .at_top_i    (at_top),
            .at_bottom_i (at_bottom),
            .down_i      (down_q),
            .pwm_i       (pwm),
            .fast_i      (fast),
            .cmp_o       (chan_cmp[g]),
            .act_o       (chan_act[g]),
            .match_o     (chan_match[g]),
            .wave_o      (chan_wave[g])
        );
    end

    assign cmp_a   = chan_cmp[0];
    assign cmp_b   = chan_cmp[1];
    assign match_a = chan_match[0];
    assign match_b = chan_match[1];
    assign wave_a  = chan_wave[0];
    assign wave_b  = chan_wave[1];

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q    <= tmw_ctrl_s'(6'h00);
            top_bit_q <= 1'b0;
            clk_sel_q <= 3'h0;
            div_q     <= `TMW_TICK_DIV_RST;
            mask_q    <= 3'h0;
        end else if (wr.we) begin
            case (wr.adr)
                `TMW_ADR_CTRL_A: begin
                    ctrl_q.mode_a <= wr.dat[`TMW_CA_MODE_HI:`TMW_CA_MODE_LO];
                    ctrl_q.mode_b <= wr.dat[`TMW_CB_MODE_HI:`TMW_CB_MODE_LO];
                    ctrl_q.wm_low <= wr.dat[`TMW_WM_LOW_HI:0];
                end
                `TMW_ADR_CTRL_B: begin
                    top_bit_q <= wr.dat[`TMW_WM_TOP_BIT];
                    clk_sel_q <= wr.dat[2:0];
                end
                `TMW_ADR_IRQ_MASK: mask_q <= wr.dat[2:0];
                `TMW_ADR_TICK_DIV: div_q  <= wr.dat;
                default: ;
            endcase
        end
    end

    // sticky events; a new event wins over a write-one clear
    assign ev = {match_b, match_a, ovf_ev};
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= 3'h0;
        end else if (wr.we && wr.adr == `TMW_ADR_IRQ_STAT) begin
            stat_q <= (stat_q & ~wr.dat[2:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    // single-cycle ack, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= 32'h0000_0000;
            if (bus_req && !we_i) begin
                case (adr_i)
                    `TMW_ADR_CTRL_A: rdat_q[7:0] <= {ctrl_q.mode_a, ctrl_q.mode_b, 2'b00, ctrl_q.wm_low};
                    `TMW_ADR_CTRL_B: rdat_q[7:0] <= {4'h0, top_bit_q, clk_sel_q};
                    `TMW_ADR_COUNT:  rdat_q[7:0] <= count_q;
                    `TMW_ADR_CMP_A:  rdat_q[7:0] <= cmp_a;
                    `TMW_ADR_CMP_B:  rdat_q[7:0] <= cmp_b;
                    `TMW_ADR_IRQ_STAT: rdat_q[7:0] <= {5'h00, stat_q};
                    `TMW_ADR_IRQ_MASK: rdat_q[7:0] <= {5'h00, mask_q};
                    `TMW_ADR_TICK_DIV: rdat_q[7:0] <= div_q;
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // pins and interrupt registered so outputs come from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_q    <= 1'b0;
            pa_en_q <= 1'b0;
            pb_q    <= 1'b0;
            pb_en_q <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            pa_q    <= wave_a;
            pa_en_q <= (ctrl_q.mode_a != 2'b00);
            pb_q    <= wave_b;
            pb_en_q <= (ctrl_q.mode_b != 2'b00);
            irq_q   <= |(stat_q & mask_q);
        end
    end

    assign dat_o             = rdat_q;
    assign ack_o             = ack_q;
    assign chan_a_wave_out_o = pa_q;
    assign chan_a_wave_en_o  = pa_en_q;
    assign chan_b_wave_out_o = pb_q;
    assign chan_b_wave_en_o  = pb_en_q;
    assign irq_o             = irq_q;
endmodule : tmw_timer

// ---- testbench/tmw_timer_properties.sv ----
// checker: bus handshake, readback and pin enable properties of the timer
`timescale 1ns/10ps
module tmw_timer_props (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // pins and interrupt
    input wire logic        chan_a_wave_out_o,
    input wire logic        chan_a_wave_en_o,
    input wire logic        chan_b_wave_out_o,
    input wire logic        chan_b_wave_en_o,
    input wire logic        irq_o
);
    logic take;
    logic wr_ctl;
    assign take   = cyc_i && stb_i && !ack_o;
    assign wr_ctl = take && we_i && sel_i[0] && adr_i == 4'h0;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (take |=> ack_o) else $error("no ack after request");
    chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    chk_ack_cause: assert property (!take |=> !ack_o) else $error("ack without request");
    chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
    chk_rsvd_zero: assert property (take && !we_i && adr_i == 4'h0 |=> dat_o[3:2] == 2'h0)
        else $error("reserved control bits read nonzero");
    chk_unmap_zero: assert property (take && !we_i && adr_i[3] |=> dat_o == 32'h0)
        else $error("unmapped read nonzero");
    chk_en_a_mode: assert property (wr_ctl |-> ##2 chan_a_wave_en_o == ($past(dat_i[7:6], 2) != 2'h0))
        else $error("channel a enable wrong");
    chk_en_b_mode: assert property (wr_ctl |-> ##2 chan_b_wave_en_o == ($past(dat_i[5:4], 2) != 2'h0))
        else $error("channel b enable wrong");
    chk_en_hold: assert property ($changed(chan_a_wave_en_o) |-> $past(wr_ctl) || $past(wr_ctl, 2))
        else $error("enable moved without write");
    chk_irq_masked: assert property (take && we_i && sel_i[0] && adr_i == 4'h6 && dat_i[2:0] == 3'h0
        |-> ##2 !irq_o) else $error("masked interrupt raised");
endmodule : tmw_timer_props
bind tmw_timer tmw_timer_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .chan_a_wave_out_o(chan_a_wave_out_o), .chan_a_wave_en_o(chan_a_wave_en_o),
    .chan_b_wave_out_o(chan_b_wave_out_o), .chan_b_wave_en_o(chan_b_wave_en_o), .irq_o(irq_o));

// ---- testbench/tmw_timer_tb.sv ----
// self-checking bench for the waveform timer
`timescale 1ns/10ps
module tmw_timer_tb;
    typedef struct {
        logic [7:0] ca, cb, va, vb;
        int         win, ha, hb, ta;
    } tmw_row_s;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [3:0]  adr_i = 4'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o, a_out, a_en, b_out, b_en, irq, pa;
    logic [7:0]  rd;
    int          bad_count = 0;
    int          num_checks = 0;
    int          ha, hb, ta, n;
    // ctrl a, ctrl b, cmp a, cmp b, window, high a, high b, toggles a (-1 skips)
    tmw_row_s rows[7] = '{
        '{8'h40, 8'h01, 8'h10, 8'h00, 1024, -1, -1, 4},
        '{8'hE0, 8'h01, 8'h10, 8'h80, 1024, 1024, 0, -1},
        '{8'hB3, 8'h01, 8'h3F, 8'hBF, 1024, 256, 256, -1},
        '{8'hB1, 8'h01, 8'h40, 8'h40, 1020, 256, 764, -1},
        '{8'h63, 8'h09, 8'h3F, 8'h1F, 1024, -1, 512, 16},
        '{8'hC3, 8'h09, 8'h3F, 8'h1F, 1024, 0, -1, -1},
        '{8'h43, 8'h01, 8'h3F, 8'h1F, 1024, -1, -1, 0}};
    always #2 clk_i = ~clk_i;
    tmw_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .chan_a_wave_out_o(a_out),
        .chan_a_wave_en_o(a_en), .chan_b_wave_out_o(b_out), .chan_b_wave_en_o(b_en), .irq_o(irq));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk
    // single classic cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        int k;
        k = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        if (k >= 50)
            bad_count++;
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask : wr
    // counts high cycles and toggles; duty is phase-free over whole periods
    task automatic meas(input int w);
        ha = 0;
        hb = 0;
        ta = 0;
        pa = a_out;
        repeat (w) begin
            @(posedge clk_i);
            ha += int'(a_out === 1'b1);
            hb += int'(b_out === 1'b1);
            ta += int'(a_out !== pa);
            pa = a_out;
        end
    endtask : meas
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({29'h0, a_en, b_en, irq}, 32'h0);
        foreach (rows[i]) begin
            wr(4'h1, 8'h00);
            wr(4'h0, rows[i].ca);
            wr(4'h3, rows[i].va);
            wr(4'h4, rows[i].vb);
            wr(4'h2, 8'h00);
            wr(4'h1, rows[i].cb);
            // in the PWM modes active compares load from the buffers only at TOP, so let a full period pass
            repeat (600) @(posedge clk_i);
            meas(rows[i].win);
            chk({a_en, b_en}, {rows[i].ca[7:6] != 2'h0, rows[i].ca[5:4] != 2'h0});
            if (rows[i].ha >= 0)
                chk(ha, rows[i].ha);
            if (rows[i].hb >= 0)
                chk(hb, rows[i].hb);
            if (rows[i].ta >= 0)
                chk(ta, rows[i].ta);
        end
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        wr(4'h5, 8'h07);
        wr(4'h6, 8'h01);
        wr(4'h2, 8'hF0);
        chk(irq, 1'b0);
        wr(4'h1, 8'h01);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk(irq, 1'b1);
        wr(4'h6, 8'h00);
        chk(irq, 1'b0);
        wr(4'h1, 8'h00);
        wb(1'b0, 4'h5, 8'h00, 4'hF);
        chk(rd[0], 1'b1);
        wr(4'h5, 8'h01);
        wr(4'h6, 8'h01);
        wb(1'b0, 4'h5, 8'h00, 4'hF);
        chk({rd[0], irq}, 2'b00);
        // second reset mid-run with pins enabled and the timer running
        wr(4'h0, 8'hFF);
        wr(4'h1, 8'h01);
        rst_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({29'h0, a_en, b_en, irq}, 32'h0);
        for (int a = 0; a < 9; a++) begin
            wb(1'b0, a[3:0], 8'h00, 4'hF);
            chk(rd, 8'h00);
        end
        wr(4'h0, 8'hFF);
        wb(1'b0, 4'h0, 8'h00, 4'hF);
        chk(rd, 8'hF3);
        wb(1'b1, 4'h0, 8'h00, 4'h0);
        wr(4'h9, 8'hFF);
        wr(4'h1, 8'h08);
        wb(1'b0, 4'h0, 8'h00, 4'hF);
        chk(rd, 8'hF3);
        wb(1'b0, 4'h1, 8'h00, 4'hF);
        chk(rd[3], 1'b1);
        end_of_test();
    end
endmodule : tmw_timer_tb
